// file: design/fcrc_top.sv
// Purpose: CPU reprogramming control of the user flash, reached over APB
// Assumes: Commands arrive as APB writes to the command word with a target address
// Notes: Array timing is modelled by counters; the cell array itself is outside
//
// The register addresses and register access over APB were left to the implementer.
`include "fcrc_regs.svh"
// Behaviour
// R1 - Commands target the region being reprogrammed
// R2 - Erasure may suspend to serve interrupts
// R3 - User ROM readable while erase suspended
// R4 - RAM mode program runs from RAM
// R5 - Flash mode never targets own block
// R6 - Read-array state after every command
// R7 - Flash mode holds CPU and ports
// R8 - Status shows program, erase, blank flags
// R9 - RAM mode: enable and request suspend
// R10 - RAM mode: enable, irq enable, irq suspend
// R11 - Flash mode: enable and irq suspend
// R12 - RAM mode raises ready and busy-read irqs
// R13 - Flash mode raises no flash irqs
// R14 - Transfer controller avoids ROM during processing
// R15 - No transfer controller with RAM program
// R16 - RAM mode selection order by software
// R17 - Wait then check ready before reading
// R18 - Clearing request resumes erasure
// R19 - Vectors and handlers placed in RAM
// R20 - Slow bus clock before reading ROM
// R21 - Flash mode: select bit, then enable
// R22 - Flash mode irq only after transition time
// R23 - Flash mode irq sets suspend request
// R24 - Software clears request to resume
// R25 - Ready rise clears enable and lock-disable
// R26 - Suspend without erasure does nothing
module fcrc_top
  import fcrc_pkg::*;
#(
  parameter int PROG_CYC = `FCRC_PROG_CYC,
  parameter int ERASE_CYC = `FCRC_ERASE_CYC,
  parameter int SUSP_CYC = `FCRC_SUSP_CYC,
  parameter int ADDR_W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pin,
  input wire logic rom_read,
  output logic rom_read_ok,
  output logic cpu_hold,
  output logic port_hold,
  output logic flash_irq,
  output logic [ADDR_W-1:0] op_addr
);
  import fcrc_pkg::*;
  localparam int TW = 32;
  initial begin
    if (ADDR_W < 8 || ADDR_W > 24) $error("fcrc_top address width out of range");
    if (PROG_CYC < 1 || ERASE_CYC < 2 || SUSP_CYC < 1) $error("fcrc_top counts must be positive");
  end
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction
  logic wr_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = hit(paddr, `FCRC_OFS_CTRL1) || hit(paddr, `FCRC_OFS_CTRL2) ||
                  hit(paddr, `FCRC_OFS_STAT) || hit(paddr, `FCRC_OFS_CMD) || hit(paddr, `FCRC_OFS_REGION);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic cmd_en, mode_sel, wus, lock_dis;
  logic sp_en, sp_req, isp_en, bsyrd_ie, rdy_ie;
  logic prs, ers, ebs;
  logic [ADDR_W-1:0] region_base;
  logic [ADDR_W-1:0] next_region_base;
  logic [ADDR_W-1:0] next_op_addr;
  logic next_cmd_en, next_mode_sel, next_wus, next_lock_dis;
  logic next_sp_en, next_sp_req, next_isp_en, next_bsyrd_ie, next_rdy_ie;
  logic next_prs, next_ers, next_ebs;
  fcrc_state_t state, next_state;
  fcrc_op_t op, next_op;
  logic [31:0] next_prdata;
  logic next_flash_irq;
  logic irq_s;
  logic [TW-1:0] grace;
  logic [TW-1:0] next_grace;
  logic t_load, t_busy, t_done;
  logic [TW-1:0] t_val;
  logic ready_flag;
  logic busy_q;
  logic cmd_go;
  logic [1:0] cmd_code;
  logic susp_go;
  fcrc_sync u_irq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(irq_pin),
    .dout(irq_s)
  );
  fcrc_timer #(.WIDTH(TW)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(t_load),
    .load_val(t_val),
    .pause(state == FCRC_SUSP),
    .busy(t_busy),
    .done(t_done)
  );
  assign ready_flag = (state == FCRC_IDLE) || (state == FCRC_SUSP); // R17
  assign cmd_code = pwdata[1:0];
  // Command accepted only with commands enabled and a target at or above the chosen region base
  assign cmd_go = wr_acc && hit(paddr, `FCRC_OFS_CMD) && cmd_en && state == FCRC_IDLE &&
                  cmd_code != 2'h0 && {8'h0, pwdata[31:8]} >= 32'(region_base); // R1
  // ----------------------------------------
  // Suspend decision
  // ----------------------------------------
  always_comb begin
    susp_go = 1'b0;
    // Not once the count is spent: the done pulse would be lost
    if (state == FCRC_RUN && op == FCRC_OP_ERASE && sp_en && t_busy) begin // R26
      if (!mode_sel) begin
        susp_go = sp_req || (isp_en && irq_s); // R9 R10
      end else begin
        susp_go = sp_req || (irq_s && grace == '0); // R11 R22
      end
    end
  end
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_op = op;
    next_op_addr = op_addr;
    next_region_base = region_base;
    next_cmd_en = cmd_en;
    next_mode_sel = mode_sel;
    next_wus = wus;
    next_lock_dis = lock_dis;
    next_sp_en = sp_en;
    next_sp_req = sp_req;
    next_isp_en = isp_en;
    next_bsyrd_ie = bsyrd_ie;
    next_rdy_ie = rdy_ie;
    next_prs = prs;
    next_ers = ers;
    next_ebs = ebs;
    next_grace = (grace != '0) ? grace - 1'b1 : grace;
    next_flash_irq = 1'b0;
    t_load = 1'b0;
    t_val = '0;
    if (wr_acc && hit(paddr, `FCRC_OFS_CTRL1)) begin
      next_cmd_en = pwdata[`FCRC_C1_CMDEN];
      next_mode_sel = pwdata[`FCRC_C1_MODE];
      next_wus = pwdata[`FCRC_C1_WUS];
      next_lock_dis = pwdata[`FCRC_C1_LBD];
    end
    if (wr_acc && hit(paddr, `FCRC_OFS_CTRL2)) begin
      next_sp_en = pwdata[`FCRC_C2_SPEN];
      next_sp_req = pwdata[`FCRC_C2_SPREQ];
      next_isp_en = pwdata[`FCRC_C2_ISPE];
      next_bsyrd_ie = pwdata[`FCRC_C2_BSYRDIE];
      next_rdy_ie = pwdata[`FCRC_C2_RDYIE];
    end
    if (wr_acc && hit(paddr, `FCRC_OFS_REGION)) begin
      next_region_base = pwdata[ADDR_W-1:0];
    end
    case (state)
      FCRC_IDLE: begin
        if (cmd_go) begin
          next_op = fcrc_op_t'(cmd_code);
          next_op_addr = pwdata[ADDR_W+7:8];
          next_state = FCRC_RUN;
          t_load = 1'b1;
          t_val = (cmd_code == `FCRC_CMD_ERASE) ? TW'(ERASE_CYC) : TW'(PROG_CYC);
          next_grace = TW'(SUSP_CYC); // R22
          next_prs = (cmd_code == `FCRC_CMD_PROG);
          next_ers = (cmd_code == `FCRC_CMD_ERASE);
          next_ebs = (cmd_code == `FCRC_CMD_BLANK);
        end
      end
      FCRC_RUN: begin
        if (susp_go) begin
          next_state = FCRC_SUSP; // R2
          // Held in both modes so that only a software clear resumes
          next_sp_req = 1'b1; // R23
        end else if (t_done) begin
          next_state = FCRC_DONE;
        end
      end
      FCRC_SUSP: begin
        if (!next_sp_req) begin
          next_state = FCRC_RUN; // R18
        end
      end
      FCRC_DONE: begin
        next_state = FCRC_IDLE; // R6
        next_op = FCRC_OP_NONE;
        next_prs = 1'b0;
        next_ers = 1'b0;
        next_ebs = 1'b0;
        next_cmd_en = 1'b0; // R25
        next_lock_dis = 1'b0; // R25
        next_flash_irq = !mode_sel && rdy_ie; // R12 R13
      end
      default: begin
        next_state = FCRC_IDLE;
      end
    endcase
    if (!mode_sel && bsyrd_ie && rom_read && busy_q && state != FCRC_SUSP) begin
      next_flash_irq = 1'b1; // R12 R13
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    next_prdata = '0;
    if (psel && !penable && !pwrite) begin
      if (hit(paddr, `FCRC_OFS_CTRL1)) begin
        next_prdata = {28'h0, lock_dis, wus, mode_sel, cmd_en};
      end else if (hit(paddr, `FCRC_OFS_CTRL2)) begin
        next_prdata = {27'h0, rdy_ie, bsyrd_ie, isp_en, sp_req, sp_en};
      end else if (hit(paddr, `FCRC_OFS_STAT)) begin
        next_prdata = {24'h0, ready_flag, 1'b0, ers, prs, ebs, 2'h0, state == FCRC_SUSP}; // R8
      end else if (hit(paddr, `FCRC_OFS_REGION)) begin
        next_prdata = 32'(region_base);
      end
    end else begin
      next_prdata = prdata;
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FCRC_IDLE;
      op <= FCRC_OP_NONE;
      op_addr <= '0;
      region_base <= '0;
      {lock_dis, wus, mode_sel, cmd_en} <= 4'(`FCRC_C1_RESET);
      {rdy_ie, bsyrd_ie, isp_en, sp_req, sp_en} <= 5'h00;
      {prs, ers, ebs} <= 3'h0;
      grace <= '0;
      prdata <= '0;
      flash_irq <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      op_addr <= next_op_addr;
      region_base <= next_region_base;
      {lock_dis, wus, mode_sel, cmd_en} <= {next_lock_dis, next_wus, next_mode_sel, next_cmd_en};
      {rdy_ie, bsyrd_ie, isp_en, sp_req, sp_en} <= {next_rdy_ie, next_bsyrd_ie, next_isp_en, next_sp_req, next_sp_en};
      {prs, ers, ebs} <= {next_prs, next_ers, next_ebs};
      grace <= next_grace;
      prdata <= next_prdata;
      flash_irq <= next_flash_irq;
      busy_q <= t_busy;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rom_read_ok = ready_flag; // R3
  assign cpu_hold = mode_sel && state == FCRC_RUN; // R7
  assign port_hold = cpu_hold; // R7
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_done_idle;
    @(posedge pclk) disable iff (!presetn) state == FCRC_DONE |=> state == FCRC_IDLE && !cmd_en;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("no return to read array"); // R6
  property p_hold;
    @(posedge pclk) disable iff (!presetn) (cmd_go && mode_sel) |=> cpu_hold && port_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("cpu not held in flash mode"); // R7
  property p_ers_flag;
    @(posedge pclk) disable iff (!presetn) (state == FCRC_RUN && op == FCRC_OP_ERASE) |-> ers && !prs;
  endproperty
  a_ers_flag: assert property (p_ers_flag) else $error("erase flag wrong"); // R8
  property p_req_susp;
    @(posedge pclk) disable iff (!presetn)
      (state == FCRC_RUN && op == FCRC_OP_ERASE && !mode_sel && sp_en && sp_req && t_busy) |=> state == FCRC_SUSP;
  endproperty
  a_req_susp: assert property (p_req_susp) else $error("request did not suspend"); // R9
  property p_irq_susp0;
    @(posedge pclk) disable iff (!presetn)
      (state == FCRC_RUN && op == FCRC_OP_ERASE && !mode_sel && sp_en && isp_en && irq_s && t_busy)
      |=> state == FCRC_SUSP;
  endproperty
  a_irq_susp0: assert property (p_irq_susp0) else $error("irq did not suspend"); // R10
  property p_irq_susp1;
    @(posedge pclk) disable iff (!presetn)
      (state == FCRC_RUN && op == FCRC_OP_ERASE && mode_sel && sp_en && irq_s && grace == '0 && t_busy)
      |=> state == FCRC_SUSP && sp_req;
  endproperty
  a_irq_susp1: assert property (p_irq_susp1) else $error("flash mode irq did not suspend"); // R23
  property p_grace;
    @(posedge pclk) disable iff (!presetn)
      (state == FCRC_RUN && mode_sel && !sp_req && grace != '0) |=> state != FCRC_SUSP;
  endproperty
  a_grace: assert property (p_grace) else $error("suspend before transition time"); // R22
  property p_resume;
    @(posedge pclk) disable iff (!presetn)
      (state == FCRC_SUSP && wr_acc && hit(paddr, `FCRC_OFS_CTRL2) && !pwdata[`FCRC_C2_SPREQ]) |=> state == FCRC_RUN;
  endproperty
  a_resume: assert property (p_resume) else $error("clear did not resume"); // R18
  property p_no_irq1;
    @(posedge pclk) disable iff (!presetn) $past(mode_sel) && mode_sel |-> !flash_irq;
  endproperty
  a_no_irq1: assert property (p_no_irq1) else $error("irq raised in flash mode"); // R13
  property p_idle_nosusp;
    @(posedge pclk) disable iff (!presetn) state == FCRC_IDLE |=> state != FCRC_SUSP;
  endproperty
  a_idle_nosusp: assert property (p_idle_nosusp) else $error("suspend without erase"); // R26
  property p_susp_read;
    @(posedge pclk) disable iff (!presetn) state == FCRC_SUSP |-> rom_read_ok;
  endproperty
  a_susp_read: assert property (p_susp_read) else $error("rom not readable in suspend"); // R3
endmodule

// file: design/fcrc_regs.svh
// Purpose: Register map, field positions and timing figures of the flash reprogram control
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes: Definitions only
`ifndef FCRC_REGS_SVH
`define FCRC_REGS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define FCRC_OFS_CTRL1 12'h000
`define FCRC_OFS_CTRL2 12'h004
`define FCRC_OFS_STAT 12'h008
`define FCRC_OFS_CMD 12'h00c
`define FCRC_OFS_REGION 12'h010
// ----------------------------------------
// Control register one fields
// ----------------------------------------
`define FCRC_C1_CMDEN 0
`define FCRC_C1_MODE 1
`define FCRC_C1_WUS 2
`define FCRC_C1_LBD 3
`define FCRC_C1_RESET 32'h0000_0004
// ----------------------------------------
// Control register two fields
// ----------------------------------------
`define FCRC_C2_SPEN 0
`define FCRC_C2_SPREQ 1
`define FCRC_C2_ISPE 2
`define FCRC_C2_BSYRDIE 3
`define FCRC_C2_RDYIE 4
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FCRC_ST_RDY 7
`define FCRC_ST_ERS 5
`define FCRC_ST_PRS 4
`define FCRC_ST_EBS 3
`define FCRC_ST_SUSP 0
// ----------------------------------------
// Command word
// ----------------------------------------
`define FCRC_CMD_PROG 2'h1
`define FCRC_CMD_ERASE 2'h2
`define FCRC_CMD_BLANK 2'h3
// ----------------------------------------
// Timing, in microseconds at 200 MHz
// ----------------------------------------
`define FCRC_CLK_MHZ 200
`define FCRC_SUSP_US 50
`define FCRC_SUSP_CYC (`FCRC_SUSP_US * `FCRC_CLK_MHZ)
`define FCRC_PROG_US 150
`define FCRC_PROG_CYC (`FCRC_PROG_US * `FCRC_CLK_MHZ)
`define FCRC_ERASE_US 200000
`define FCRC_ERASE_CYC (`FCRC_ERASE_US * `FCRC_CLK_MHZ)
`endif

// file: design/fcrc_pkg.sv
// Purpose: Types shared by the flash reprogram control files
// Assumes: Nothing
// Notes: Gray codes along idle, run, suspend
package fcrc_pkg;
  typedef enum logic [1:0] {
    FCRC_IDLE = 2'h0,
    FCRC_RUN = 2'h1,
    FCRC_SUSP = 2'h3,
    FCRC_DONE = 2'h2
  } fcrc_state_t;
  typedef enum logic [1:0] {
    FCRC_OP_NONE = 2'h0,
    FCRC_OP_PROG = 2'h1,
    FCRC_OP_ERASE = 2'h2,
    FCRC_OP_BLANK = 2'h3
  } fcrc_op_t;
endpackage

// file: design/fcrc_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin level
// Assumes: Input from outside the pclk domain
// Notes: First stage feeds only the second
module fcrc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;
  always_comb begin
    next_dout = dout;
    if (s2 == s3) begin
      next_dout = s3;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule

// file: design/fcrc_timer.sv
// Purpose: Down counter that times an operation, frozen while paused
// Assumes: Load wins over pause
// Notes: Done is a one-cycle pulse on reaching zero
module fcrc_timer #(
  parameter int WIDTH = 26
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic pause,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_done;
  initial begin
    if (WIDTH < 2) $error("fcrc_timer width too small");
  end
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != '0 && !pause) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
  assign busy = (cnt != '0);
endmodule

// file: testbench/fcrc_cpu_model.sv
// Purpose: Bus-master side model that raises interrupts and reads user ROM
// Assumes: Requests come from the bench one cycle ahead
// Notes: Levels change only after a rising edge
module fcrc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic rd_req,
  output logic irq_pin,
  output logic rom_read
);
  timeunit 1ns;
  timeprecision 1ps;
  // Reads only when the bench asks, so stray busy reads never occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin <= 1'b0;
      rom_read <= 1'b0;
    end else begin
      irq_pin <= irq_req;
      rom_read <= rd_req;
    end
  end
endmodule

// file: testbench/fcrc_top_tb.sv
// Purpose: Self-checking bench for the flash reprogram control
// Assumes: Short operation counts set through parameters
// Notes: Registers reached by APB tasks only
`include "fcrc_regs.svh"
module fcrc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_req = 1'b0;
  logic rd_req = 1'b0;
  logic irq_pin;
  logic rom_read;
  logic rom_read_ok;
  logic cpu_hold;
  logic port_hold;
  logic flash_irq;
  logic [23:0] op_addr;
  logic [31:0] rd;
  logic er;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int irqs = 0;
  int snap;
  always #2.5 pclk = ~pclk;
  fcrc_top #(.PROG_CYC(20), .ERASE_CYC(50), .SUSP_CYC(5), .ADDR_W(24)) i_fcrc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin(irq_pin), .rom_read(rom_read), .rom_read_ok(rom_read_ok), .cpu_hold(cpu_hold),
    .port_hold(port_hold), .flash_irq(flash_irq), .op_addr(op_addr)
  );
  fcrc_cpu_model i_fcrc_cpu_model (
    .pclk(pclk), .presetn(presetn), .irq_req(irq_req), .rd_req(rd_req),
    .irq_pin(irq_pin), .rom_read(rom_read)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic wait_ready;
    repeat (200) begin
      apb(1'b0, `FCRC_OFS_STAT, 32'h0);
      if (rd[7] === 1'b1) break;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches++;
      conclude();
    end
  end
  always @(posedge pclk) if (flash_irq === 1'b1) irqs <= irqs + 1;
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    idle(20);
    presetn <= 1'b1;
    rchk(`FCRC_OFS_CTRL1, '1, 32'h4);
    rchk(`FCRC_OFS_CTRL2, '1, 32'h0);
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h3);
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    chk({31'h0, rom_read_ok}, 32'h1);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h18);
    apb(1'b1, `FCRC_OFS_REGION, 32'h100);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hc);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hd);
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3401);
    rchk(`FCRC_OFS_STAT, '1, 32'h10);
    chk({8'h0, op_addr}, 32'h1234);
    chk({30'h0, rom_read_ok, cpu_hold}, 32'h0);
    rd_req <= 1'b1;
    idle(1);
    rd_req <= 1'b0;
    idle(3);
    chk(32'(irqs), 32'h1);
    wait_ready();
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    rchk(`FCRC_OFS_CTRL1, '1, 32'h4);
    chk(32'(irqs), 32'h2);
    // Enable is gone, so this command must be ignored
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3402);
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h0);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hd);
    // Target below the region base must be refused
    apb(1'b1, `FCRC_OFS_CMD, 32'h0000_5003);
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3403);
    rchk(`FCRC_OFS_STAT, '1, 32'h08);
    wait_ready();
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hc);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hd);
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3402);
    rchk(`FCRC_OFS_STAT, '1, 32'h20);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h3);
    idle(4);
    rchk(`FCRC_OFS_STAT, 32'ha1, 32'ha1);
    chk({31'h0, rom_read_ok}, 32'h1);
    idle(60);
    rchk(`FCRC_OFS_STAT, 32'h21, 32'h21);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h1);
    rchk(`FCRC_OFS_STAT, 32'h21, 32'h20);
    wait_ready();
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hc);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'hd);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h5);
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3402);
    irq_req <= 1'b1;
    idle(8);
    rchk(`FCRC_OFS_STAT, 32'h21, 32'h21);
    irq_req <= 1'b0;
    // Let the synchroniser drain before clearing
    idle(8);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h0);
    wait_ready();
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    snap = irqs;
    apb(1'b1, `FCRC_OFS_CTRL1, 32'h6);
    apb(1'b1, `FCRC_OFS_CTRL1, 32'h7);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h19);
    apb(1'b1, `FCRC_OFS_CMD, 32'h0012_3402);
    rd_req <= 1'b1;
    irq_req <= 1'b1;
    idle(1);
    chk({30'h0, cpu_hold, port_hold}, 32'h3);
    rd_req <= 1'b0;
    idle(12);
    rchk(`FCRC_OFS_CTRL2, 32'h2, 32'h2);
    rchk(`FCRC_OFS_STAT, 32'h21, 32'h21);
    chk({31'h0, rom_read_ok}, 32'h1);
    irq_req <= 1'b0;
    idle(8);
    apb(1'b1, `FCRC_OFS_CTRL2, 32'h19);
    wait_ready();
    rchk(`FCRC_OFS_STAT, '1, 32'h80);
    chk({31'h0, cpu_hold}, 32'h0);
    chk(32'(irqs), 32'(snap));
    conclude();
  end
endmodule
